// File: core/antenna_error_masked_status_pkg.sv
// constants, register map and carrier types for the antenna error masked status block
// How it works
// - separate masked status sets: per link for events 0 and 1, shared for 2 and 3
// - masked status read value is raw status AND mask
// - masked status has no storage; read value is computed from raw and mask
// - writing 1 clears the raw bit and so the masked bit; 0 does nothing
// - source assertion in the clearing cycle wins; bit stays set
// - A bits 28..24: protocol decoder errors
// - A bit 20: unexpected input frame boundary, CPRI only
// - A bit 16: serdes loss of signal
// - A bit 15: receiver in state 0 or 1; bit 14: receiver in state 3
// - A bits 13..9: received CPRI alarm flags from control byte Z.130.0
// - A bit 8: K30.7 character seen, OBSAI only
// - A bit 7: master frame boundary outside the valid window
// - A bit 6: frame marker character missing in state three
// - A bit 5: K28.5 missing in state three, OBSAI only
// - A bit 4: block or hyperframe edge; bit 3: master frame edge
// - A bit 2 decode fault, bit 1 loss threshold hit, bit 0 rx state change
// - B bit 24: control word comma mismatch
// - B bits 20..16: circuit-switch data buffer faults
// - B bit 13 combiner fifo underrun, bit 12 overrun
// - B bit 10 sum overrun, 9 frame misalign, 8 header fault
// - B bit 3 tx fifo overrun, 2 data misaligned, 1 frame strobe misaligned
// - B bit 0: tx state machine changed state
// - event output driven only by masked bits; mask set writes 1s, reads masks
package antenna_error_masked_status_pkg;

   localparam int          NUM_LINKS   = 6;
   localparam int          NUM_SLOTS   = 14;
   localparam int          NUM_EVENTS  = 4;
   localparam int          SHARED_SLOT = 12;
   localparam int          ADDR_W      = 12;
   localparam int          DATA_W      = 32;

   // address fields
   localparam int          GRP_LSB     = 8;
   localparam int          EV_LSB      = 6;
   localparam int          LINK_LSB    = 3;
   localparam int          SEL_B_BIT   = 2;
   localparam logic [1:0]  GRP_MASKED  = 2'h0;
   localparam logic [1:0]  GRP_MSK_SET = 2'h1;
   localparam logic [1:0]  GRP_MSK_CLR = 2'h2;
   localparam logic [1:0]  GRP_RAW     = 2'h3;

   localparam logic [31:0] VALID_A     = 32'h1F11_FFFF;
   localparam logic [31:0] VALID_B     = 32'h011F_370F;
   localparam logic [31:0] RESET_VAL   = 32'h0000_0000;

   // register A field positions
   localparam int A_HFN = 28, A_TYPE = 27, A_ADR = 26, A_FSYNC = 25, A_TSTAMP = 24;
   localparam int A_CI_FSYNC = 20, A_SERDES_SIGNAL_LOST = 16, A_LOF_ST = 15, A_HFN_ST = 14;
   localparam int A_R_LOF = 13, A_R_LOS = 12, A_R_SDI = 11, A_R_RAI = 10, A_R_RST = 9;
   localparam int A_K307 = 8, A_WIN = 7, A_MARK = 6, A_COMMA = 5, A_BLOCK = 4;
   localparam int A_FRAME = 3, A_DEC = 2, A_LOS_THR = 1, A_RX_CHG = 0;

   // register B field positions
   localparam int B_CWORD = 24, B_OUT_UND = 20, B_IN_UND = 19, B_BURST = 18;
   localparam int B_OUT_OVR = 17, B_IN_OVR = 16, B_CD_UND = 13, B_CD_OVR = 12;
   localparam int B_SUM = 10, B_ALIGN = 9, B_HDR = 8, B_TX_OVR = 3, B_TX_DAT = 2;
   localparam int B_TX_FRM = 1, B_TX_CHG = 0;

   typedef struct packed {
      logic              wr;
      logic              rd;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } reg_req_t;

   // one link's error and alarm sources, high while asserted
   typedef struct packed {
      logic hyperframe_number_mismatch;
      logic illegal_header_type;
      logic illegal_header_address;
      logic frame_sync_char_mismatch;
      logic timestamp_fault;
      logic unexpected_input_frame_boundary;
      logic serdes_signal_lost;
      logic rx_frame_lost_state;
      logic rx_hyperframe_sync_state;
      logic rx_remote_frame_loss;
      logic rx_remote_signal_loss;
      logic rx_remote_sdi_alarm;
      logic rx_remote_alarm_ind;
      logic rx_remote_reset_req;
      logic error_char_detected;
      logic master_frame_window_fault;
      logic frame_marker_missing;
      logic comma_char_missing;
      logic block_edge_seen;
      logic frame_edge_seen;
      logic line_decode_fault;
      logic signal_loss_threshold_hit;
      logic rx_sync_state_changed;
      logic ctrl_word_comma_mismatch;
      logic circuit_out_dma_underrun;
      logic circuit_in_dma_underrun;
      logic circuit_out_burst_overrun;
      logic circuit_out_dma_overrun;
      logic circuit_in_dma_overrun;
      logic combiner_fifo_underrun;
      logic combiner_fifo_overrun;
      logic aggregate_sum_overrun;
      logic aggregate_frame_misalign;
      logic aggregate_header_fault;
      logic tx_fifo_overrun;
      logic tx_data_misaligned;
      logic tx_frame_strobe_misaligned;
      logic tx_sync_state_changed;
   } link_src_t;

endpackage

// File: core/antenna_error_masked_status.sv
// masked status, mask storage and raw status for the exception event handler
module antenna_error_masked_status (
   // clock and reset
   input  wire logic                                        i_clk,
   input  wire logic                                        i_srst,
   // register port
   input  wire antenna_error_masked_status_pkg::reg_req_t   i_req,
   output logic [antenna_error_masked_status_pkg::DATA_W-1:0] o_rdata,
   // error and alarm sources, one struct per link
   input  wire antenna_error_masked_status_pkg::link_src_t  i_link_src [antenna_error_masked_status_pkg::NUM_LINKS],
   // aggregated event lines
   output logic [antenna_error_masked_status_pkg::NUM_EVENTS-1:0] o_antenna_event_output
);

   localparam int NL = antenna_error_masked_status_pkg::NUM_LINKS;
   localparam int NS = antenna_error_masked_status_pkg::NUM_SLOTS;

   // pack register A sources into their bit positions
   function automatic logic [31:0] pack_a(input antenna_error_masked_status_pkg::link_src_t s);
      logic [31:0] v;
      v = antenna_error_masked_status_pkg::RESET_VAL;
      v[antenna_error_masked_status_pkg::A_HFN]     = s.hyperframe_number_mismatch;
      v[antenna_error_masked_status_pkg::A_TYPE]    = s.illegal_header_type;
      v[antenna_error_masked_status_pkg::A_ADR]     = s.illegal_header_address;
      v[antenna_error_masked_status_pkg::A_FSYNC]   = s.frame_sync_char_mismatch;
      v[antenna_error_masked_status_pkg::A_TSTAMP]  = s.timestamp_fault;
      v[antenna_error_masked_status_pkg::A_CI_FSYNC]= s.unexpected_input_frame_boundary;
      v[antenna_error_masked_status_pkg::A_SERDES_SIGNAL_LOST]  = s.serdes_signal_lost;
      v[antenna_error_masked_status_pkg::A_LOF_ST]  = s.rx_frame_lost_state;
      v[antenna_error_masked_status_pkg::A_HFN_ST]  = s.rx_hyperframe_sync_state;
      v[antenna_error_masked_status_pkg::A_R_LOF]   = s.rx_remote_frame_loss;
      v[antenna_error_masked_status_pkg::A_R_LOS]   = s.rx_remote_signal_loss;
      v[antenna_error_masked_status_pkg::A_R_SDI]   = s.rx_remote_sdi_alarm;
      v[antenna_error_masked_status_pkg::A_R_RAI]   = s.rx_remote_alarm_ind;
      v[antenna_error_masked_status_pkg::A_R_RST]   = s.rx_remote_reset_req;
      v[antenna_error_masked_status_pkg::A_K307]    = s.error_char_detected;
      v[antenna_error_masked_status_pkg::A_WIN]     = s.master_frame_window_fault;
      v[antenna_error_masked_status_pkg::A_MARK]    = s.frame_marker_missing;
      v[antenna_error_masked_status_pkg::A_COMMA]   = s.comma_char_missing;
      v[antenna_error_masked_status_pkg::A_BLOCK]   = s.block_edge_seen;
      v[antenna_error_masked_status_pkg::A_FRAME]   = s.frame_edge_seen;
      v[antenna_error_masked_status_pkg::A_DEC]     = s.line_decode_fault;
      v[antenna_error_masked_status_pkg::A_LOS_THR] = s.signal_loss_threshold_hit;
      v[antenna_error_masked_status_pkg::A_RX_CHG]  = s.rx_sync_state_changed;
      return v;
   endfunction

   // pack register B sources into their bit positions
   function automatic logic [31:0] pack_b(input antenna_error_masked_status_pkg::link_src_t s);
      logic [31:0] v;
      v = antenna_error_masked_status_pkg::RESET_VAL;
      v[antenna_error_masked_status_pkg::B_CWORD]   = s.ctrl_word_comma_mismatch;
      v[antenna_error_masked_status_pkg::B_OUT_UND] = s.circuit_out_dma_underrun;
      v[antenna_error_masked_status_pkg::B_IN_UND]  = s.circuit_in_dma_underrun;
      v[antenna_error_masked_status_pkg::B_BURST]   = s.circuit_out_burst_overrun;
      v[antenna_error_masked_status_pkg::B_OUT_OVR] = s.circuit_out_dma_overrun;
      v[antenna_error_masked_status_pkg::B_IN_OVR]  = s.circuit_in_dma_overrun;
      v[antenna_error_masked_status_pkg::B_CD_UND]  = s.combiner_fifo_underrun;
      v[antenna_error_masked_status_pkg::B_CD_OVR]  = s.combiner_fifo_overrun;
      v[antenna_error_masked_status_pkg::B_SUM]     = s.aggregate_sum_overrun;
      v[antenna_error_masked_status_pkg::B_ALIGN]   = s.aggregate_frame_misalign;
      v[antenna_error_masked_status_pkg::B_HDR]     = s.aggregate_header_fault;
      v[antenna_error_masked_status_pkg::B_TX_OVR]  = s.tx_fifo_overrun;
      v[antenna_error_masked_status_pkg::B_TX_DAT]  = s.tx_data_misaligned;
      v[antenna_error_masked_status_pkg::B_TX_FRM]  = s.tx_frame_strobe_misaligned;
      v[antenna_error_masked_status_pkg::B_TX_CHG]  = s.tx_sync_state_changed;
      return v;
   endfunction

   // events 0/1 own a slot per link, events 2/3 one shared slot each
   function automatic logic [3:0] slot_of(input logic [1:0] ev, input logic [2:0] link);
      logic [4:0] s;
      if (ev[1]) begin
         s = 5'(antenna_error_masked_status_pkg::SHARED_SLOT) + {4'h0, ev[0]};
      end else begin
         s = (ev[0] ? 5'(NL) : 5'h00) + {2'h0, link};
      end
      return s[3:0];
   endfunction

   // storage: raw status per link, masks per slot
   logic [31:0] raw_a_q   [NL];
   logic [31:0] raw_b_q   [NL];
   logic [31:0] mask_a_q  [NS];
   logic [31:0] mask_b_q  [NS];
   logic [31:0] rdata_q;
   logic [3:0]  event_q;

   // address decode
   wire logic [1:0] grp     = i_req.addr[antenna_error_masked_status_pkg::GRP_LSB +: 2];
   wire logic [1:0] ev      = i_req.addr[antenna_error_masked_status_pkg::EV_LSB +: 2];
   wire logic [2:0] link    = i_req.addr[antenna_error_masked_status_pkg::LINK_LSB +: 3];
   wire logic       sel_b   = i_req.addr[antenna_error_masked_status_pkg::SEL_B_BIT];
   wire logic       aligned = (i_req.addr[1:0] == 2'h0) && (i_req.addr[11:10] == 2'h0);
   wire logic       link_ok = (link < 3'(NL));
   // raw window only at event field zero; shared slots only at link zero
   wire logic       hit     = aligned && ((grp == antenna_error_masked_status_pkg::GRP_RAW) ? (link_ok && ev == 2'h0)
                                         : (ev[1] ? (link == 3'h0) : link_ok));
   wire logic [3:0] slot    = slot_of(ev, link);
   wire logic [2:0] lidx    = link_ok ? link : 3'h0;

   wire logic wr_masked  = i_req.wr && hit && (grp == antenna_error_masked_status_pkg::GRP_MASKED);
   wire logic wr_msk_set = i_req.wr && hit && (grp == antenna_error_masked_status_pkg::GRP_MSK_SET);
   wire logic wr_msk_clr = i_req.wr && hit && (grp == antenna_error_masked_status_pkg::GRP_MSK_CLR);

   // reserved bits are dropped from every write
   wire logic [31:0] wmask   = sel_b ? antenna_error_masked_status_pkg::VALID_B
                                     : antenna_error_masked_status_pkg::VALID_A;
   wire logic [31:0] wbits   = i_req.wdata & wmask;

   // source vectors and shared raw views (OR across links)
   logic [31:0] src_a [NL];
   logic [31:0] src_b [NL];
   logic [31:0] raw_a_any;
   logic [31:0] raw_b_any;
   always_comb begin
      raw_a_any = antenna_error_masked_status_pkg::RESET_VAL;
      raw_b_any = antenna_error_masked_status_pkg::RESET_VAL;
      for (int l = 0; l < NL; l++) begin
         src_a[l]  = pack_a(i_link_src[l]) & antenna_error_masked_status_pkg::VALID_A;
         src_b[l]  = pack_b(i_link_src[l]) & antenna_error_masked_status_pkg::VALID_B;
         raw_a_any = raw_a_any | raw_a_q[l];
         raw_b_any = raw_b_any | raw_b_q[l];
      end
   end

   // per-link clear strobe: a shared-slot write clears the bit on every link
   logic [NL-1:0] clr_link;
   always_comb begin
      for (int l = 0; l < NL; l++) begin
         clr_link[l] = wr_masked && (ev[1] || (lidx == 3'(l)));
      end
   end

   // raw status: set wins over a same-cycle clear
   always_ff @(posedge i_clk) begin
      for (int l = 0; l < NL; l++) begin
         if (i_srst) begin
            raw_a_q[l] <= antenna_error_masked_status_pkg::RESET_VAL;
            raw_b_q[l] <= antenna_error_masked_status_pkg::RESET_VAL;
         end else begin
            raw_a_q[l] <= (raw_a_q[l] & ~((clr_link[l] && !sel_b) ? wbits : 32'h0000_0000))
                          | src_a[l];
            raw_b_q[l] <= (raw_b_q[l] & ~((clr_link[l] && sel_b) ? wbits : 32'h0000_0000))
                          | src_b[l];
         end
      end
   end

   // masks: set register writes 1s, clear register removes them
   always_ff @(posedge i_clk) begin
      for (int s = 0; s < NS; s++) begin
         if (i_srst) begin
            mask_a_q[s] <= antenna_error_masked_status_pkg::RESET_VAL;
            mask_b_q[s] <= antenna_error_masked_status_pkg::RESET_VAL;
         end else if (slot == 4'(s) && !sel_b && (wr_msk_set || wr_msk_clr)) begin
            mask_a_q[s] <= wr_msk_set ? (mask_a_q[s] | wbits) : (mask_a_q[s] & ~wbits);
         end else if (slot == 4'(s) && sel_b && (wr_msk_set || wr_msk_clr)) begin
            mask_b_q[s] <= wr_msk_set ? (mask_b_q[s] | wbits) : (mask_b_q[s] & ~wbits);
         end
      end
   end

   // read path: masked status is only an address over raw and mask
   wire logic [31:0] raw_view  = ev[1] ? (sel_b ? raw_b_any : raw_a_any)
                                       : (sel_b ? raw_b_q[lidx] : raw_a_q[lidx]);
   wire logic [31:0] mask_view = sel_b ? mask_b_q[slot] : mask_a_q[slot];
   wire logic [31:0] masked    = raw_view & mask_view;

   logic [31:0] rd_sel;
   always_comb begin
      case (grp)
         antenna_error_masked_status_pkg::GRP_MASKED:  rd_sel = masked;
         antenna_error_masked_status_pkg::GRP_MSK_SET: rd_sel = mask_view;
         antenna_error_masked_status_pkg::GRP_MSK_CLR: rd_sel = mask_view;
         antenna_error_masked_status_pkg::GRP_RAW:     rd_sel = sel_b ? raw_b_q[lidx] : raw_a_q[lidx];
         default:                                      rd_sel = antenna_error_masked_status_pkg::RESET_VAL;
      endcase
   end

   // unmapped reads return zero; data stands only in the cycle after the strobe
   always_ff @(posedge i_clk) begin
      if (i_srst || !i_req.rd || !hit) begin
         rdata_q <= antenna_error_masked_status_pkg::RESET_VAL;
      end else begin
         rdata_q <= rd_sel & wmask;
      end
   end

   // event lines: any masked bit of the event's slots
   logic [3:0] event_d;
   always_comb begin
      event_d = 4'h0;
      for (int l = 0; l < NL; l++) begin
         event_d[0] = event_d[0] | (|(raw_a_q[l] & mask_a_q[l]))
                                 | (|(raw_b_q[l] & mask_b_q[l]));
         event_d[1] = event_d[1] | (|(raw_a_q[l] & mask_a_q[NL + l]))
                                 | (|(raw_b_q[l] & mask_b_q[NL + l]));
      end
      for (int e = 0; e < 2; e++) begin
         event_d[2 + e] = (|(raw_a_any & mask_a_q[antenna_error_masked_status_pkg::SHARED_SLOT + e]))
                        | (|(raw_b_any & mask_b_q[antenna_error_masked_status_pkg::SHARED_SLOT + e]));
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         event_q <= 4'h0;
      end else begin
         event_q <= event_d;
      end
   end

   assign o_rdata                = rdata_q;
   assign o_antenna_event_output = event_q;

endmodule

// File: sim/antenna_error_masked_status_chk.sv
// checker for the antenna error masked status block
module antenna_error_masked_status_chk (
   // clock and reset
   input wire logic                                                   i_clk,
   input wire logic                                                   i_srst,
   // register port
   input wire antenna_error_masked_status_pkg::reg_req_t              i_req,
   input wire logic [antenna_error_masked_status_pkg::DATA_W-1:0]     o_rdata,
   // sources and event lines
   input wire antenna_error_masked_status_pkg::link_src_t             i_link_src
                                                                      [antenna_error_masked_status_pkg::NUM_LINKS],
   input wire logic [antenna_error_masked_status_pkg::NUM_EVENTS-1:0] o_antenna_event_output
);
   localparam logic [11:0] MS_A0  = 12'h000;
   localparam logic [11:0] RAW_A0 = 12'h300;
   localparam logic [31:0] VA     = antenna_error_masked_status_pkg::VALID_A;
   localparam logic [31:0] VB     = antenna_error_masked_status_pkg::VALID_B;
   logic      src_any;
   wire logic hfn0 = i_link_src[0].hyperframe_number_mismatch;

   always_comb begin
      src_any = 1'b0;
      for (int l = 0; l < antenna_error_masked_status_pkg::NUM_LINKS; l++) begin
         src_any = src_any | (i_link_src[l] != '0);
      end
   end

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_srst);

   sequence s_set;
      hfn0 ##1 i_req.rd && i_req.addr == RAW_A0;
   endsequence
   sequence s_race;
      hfn0 && i_req.wr && i_req.addr == MS_A0 && i_req.wdata[28] ##1 i_req.rd && i_req.addr == RAW_A0;
   endsequence
   // the source must stay low up to the read, else a fresh set is legal
   sequence s_clr;
      !hfn0 && i_req.wr && i_req.addr == MS_A0 && i_req.wdata[28] ##1 !hfn0 ##1 !hfn0 && i_req.rd && i_req.addr == RAW_A0;
   endsequence

   property p_rd_idle;   !i_req.rd |=> o_rdata == '0; endproperty
   property p_resv_a;    i_req.rd && !i_req.addr[2] |=> (o_rdata & ~VA) == '0; endproperty
   property p_resv_b;    i_req.rd && i_req.addr[2] |=> (o_rdata & ~VB) == '0; endproperty
   property p_unmapped;  i_req.rd && i_req.addr[11:10] != 2'h0 |=> o_rdata == '0; endproperty
   property p_set;       s_set |=> o_rdata[28]; endproperty
   property p_race;      s_race |=> o_rdata[28]; endproperty
   property p_clr;       s_clr |=> !o_rdata[28]; endproperty
   // every event line counts, not only the lowest one
   property p_ev_rise;
      |(o_antenna_event_output & ~$past(o_antenna_event_output)) |-> $past(src_any || i_req.wr, 2);
   endproperty
   property p_ev_fall;
      |(~o_antenna_event_output & $past(o_antenna_event_output)) |-> $past(i_req.wr, 2);
   endproperty

   a_rd_idle:  assert property (p_rd_idle) else $error("read data not zero outside read answer");
   a_resv_a:   assert property (p_resv_a) else $error("reserved bit set in register A read");
   a_resv_b:   assert property (p_resv_b) else $error("reserved bit set in register B read");
   a_unmapped: assert property (p_unmapped) else $error("unmapped read returned data");
   a_set:      assert property (p_set) else $error("source did not set raw status");
   a_race:     assert property (p_race) else $error("clear beat simultaneous source");
   a_clr:      assert property (p_clr) else $error("write of one did not clear raw bit");
   a_ev_rise:  assert property (p_ev_rise) else $error("event rose without source or write");
   a_ev_fall:  assert property (p_ev_fall) else $error("event fell without a write");
endmodule

bind antenna_error_masked_status antenna_error_masked_status_chk chk (
   .i_clk                  (i_clk),
   .i_srst                 (i_srst),
   .i_req                  (i_req),
   .o_rdata                (o_rdata),
   .i_link_src             (i_link_src),
   .o_antenna_event_output (o_antenna_event_output)
);

// File: sim/antenna_error_masked_status_tb.sv
// self-checking bench for the antenna error masked status block
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin n_errors++; \
   $display("Error at %0t: got %h expected %h", $time, got, exp); end end
module antenna_error_masked_status_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [31:0] VA = antenna_error_masked_status_pkg::VALID_A;
   localparam logic [31:0] VB = antenna_error_masked_status_pkg::VALID_B;
   logic                                       i_clk   = 1'b0;
   logic                                       i_srst  = 1'b1;
   antenna_error_masked_status_pkg::reg_req_t  req     = '0;
   antenna_error_masked_status_pkg::link_src_t src [antenna_error_masked_status_pkg::NUM_LINKS] = '{default: '0};
   logic [31:0]                                o_rdata;
   logic [3:0]                                 o_ev;
   int                                         n_errors    = 0;
   int                                         comparisons = 0;
   // bit position of each source field, in struct order; A fields first
   int pos [38] = '{28, 27, 26, 25, 24, 20, 16, 15, 14, 13, 12, 11, 10, 9, 8, 7, 6, 5, 4, 3, 2, 1, 0,
                    24, 20, 19, 18, 17, 16, 13, 12, 10, 9, 8, 3, 2, 1, 0};

   always #5 i_clk = ~i_clk;

   antenna_error_masked_status dut (
      .i_clk                  (i_clk),
      .i_srst                 (i_srst),
      .i_req                  (req),
      .o_rdata                (o_rdata),
      .i_link_src             (src),
      .o_antenna_event_output (o_ev)
   );

   function automatic logic [11:0] adr(int g, int e, int l, int b);
      return {2'h0, 2'(g), 2'(e), 3'(l), 1'(b), 2'h0};
   endfunction

   task automatic reg_wr(logic [11:0] a, logic [31:0] v);
      @(posedge i_clk);
      req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
      @(posedge i_clk);
      req <= '0;
   endtask

   task automatic chk_rd(logic [11:0] a, logic [31:0] e);
      @(posedge i_clk);
      req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0000_0000};
      @(posedge i_clk);
      req <= '0;
      #1 `CHK(o_rdata, e)
   endtask

   // one-cycle source pulse, raw read issued on the very next edge
   task automatic pulse_rd(int l, logic [37:0] v, logic [11:0] a, logic [31:0] e);
      @(posedge i_clk);
      src[l] <= v;
      @(posedge i_clk);
      src[l] <= '0;
      req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0000_0000};
      @(posedge i_clk);
      req <= '0;
      #1 `CHK(o_rdata, e)
   endtask

   task automatic t_reset();
      for (int g = 0; g < 4; g++) for (int b = 0; b < 2; b++) chk_rd(adr(g, 0, 0, b), 32'h0000_0000);
      `CHK(o_ev, 4'h0)
   endtask

   // walk source fields k0..k1 of one link: set, check neighbour, clear
   task automatic map_range(int l, int k0, int k1);
      logic [31:0] e;
      for (int k = k0; k <= k1; k++) begin
         e = 32'h0000_0001 << pos[k];
         pulse_rd(l, 38'h1 << (37 - k), adr(3, 0, l, k > 22), e);
         chk_rd(adr(3, 0, (l + 1) % 6, k > 22), 32'h0000_0000);
         reg_wr(adr(0, 0, l, k > 22), e);
         chk_rd(adr(3, 0, l, k > 22), 32'h0000_0000);
      end
   endtask

   task automatic t_map();
      for (int l = 0; l < 6; l++) begin
         map_range(l, 0, 4);
         map_range(l, 5, 5);
         map_range(l, 6, 6);
         map_range(l, 7, 8);
         map_range(l, 9, 13);
         map_range(l, 14, 14);
         map_range(l, 15, 15);
         map_range(l, 16, 16);
         map_range(l, 17, 17);
         map_range(l, 18, 19);
         map_range(l, 20, 22);
         map_range(l, 23, 23);
         map_range(l, 24, 28);
         map_range(l, 29, 30);
         map_range(l, 31, 33);
         map_range(l, 34, 36);
         map_range(l, 37, 37);
      end
   endtask

   task automatic t_mask();
      pulse_rd(2, {23'h7F_FFFF, 15'h0000}, adr(3, 0, 2, 0), VA);
      reg_wr(adr(1, 0, 2, 0), 32'hFFFF_0F0F);
      chk_rd(adr(1, 0, 2, 0), VA & 32'hFFFF_0F0F);
      chk_rd(adr(0, 0, 2, 0), VA & 32'hFFFF_0F0F);
      chk_rd(adr(0, 1, 2, 0), 32'h0000_0000);
      `CHK(o_ev, 4'h1)
      reg_wr(adr(1, 1, 2, 0), 32'h0000_F000);
      chk_rd(adr(0, 1, 2, 0), 32'h0000_F000);
      `CHK(o_ev, 4'h3)
      reg_wr(adr(2, 0, 2, 0), 32'hFFFF_0000);
      chk_rd(adr(2, 0, 2, 0), VA & 32'h0000_0F0F);
      chk_rd(adr(0, 0, 2, 0), VA & 32'h0000_0F0F);
      reg_wr(adr(0, 0, 2, 0), 32'h0000_0000);
      chk_rd(adr(3, 0, 2, 0), VA);
      reg_wr(adr(0, 0, 2, 0), 32'hFFFF_FFFF);
      chk_rd(adr(3, 0, 2, 0), 32'h0000_0000);
      `CHK(o_ev, 4'h0)
   endtask

   task automatic t_shared();
      reg_wr(adr(1, 2, 0, 1), 32'hFFFF_FFFF);
      chk_rd(adr(1, 2, 0, 1), VB);
      pulse_rd(4, {23'h00_0000, 15'h7FFF}, adr(3, 0, 4, 1), VB);
      chk_rd(adr(0, 2, 0, 1), VB);
      chk_rd(adr(0, 3, 0, 1), 32'h0000_0000);
      `CHK(o_ev, 4'h4)
      reg_wr(adr(1, 3, 0, 1), 32'h0000_0001);
      chk_rd(adr(0, 3, 0, 1), 32'h0000_0001);
      `CHK(o_ev, 4'hC)
      reg_wr(adr(0, 2, 0, 1), 32'hFFFF_FFFF);
      chk_rd(adr(3, 0, 4, 1), 32'h0000_0000);
      `CHK(o_ev, 4'h0)
   endtask

   task automatic t_race();
      @(posedge i_clk);
      src[0] <= 38'h20_0000_0000;
      req <= '{wr: 1'b1, rd: 1'b0, addr: 12'h000, wdata: 32'h1000_0000};
      @(posedge i_clk);
      src[0] <= '0;
      req <= '{wr: 1'b0, rd: 1'b1, addr: 12'h300, wdata: 32'h0000_0000};
      @(posedge i_clk);
      req <= '0;
      #1 `CHK(o_rdata, 32'h1000_0000)
      reg_wr(12'h000, 32'h1000_0000);
      chk_rd(12'h300, 32'h0000_0000);
   endtask

   task automatic t_unmapped();
      reg_wr(12'h500, 32'hFFFF_FFFF);
      chk_rd(12'h500, 32'h0000_0000);
      reg_wr(adr(1, 0, 6, 0), 32'hFFFF_FFFF);
      chk_rd(adr(1, 0, 6, 0), 32'h0000_0000);
      chk_rd(adr(1, 0, 0, 0), 32'h0000_0000);
   endtask

   task automatic complete_run();
      if (n_errors == 0 && comparisons > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   initial begin
      repeat (3) @(posedge i_clk);
      i_srst <= 1'b0;
      t_reset();
      t_map();
      t_mask();
      t_shared();
      t_race();
      t_unmapped();
      complete_run();
   end

   // hang guard
   initial begin
      #500_000;
      n_errors++;
      complete_run();
   end
endmodule
